//--- verilog/tdbg_defines.svh
// Constants for the trace debug access and message field block
`ifndef TDBG_DEFINES_SVH
`define TDBG_DEFINES_SVH
`define TDBG_IR_W          10
`define TDBG_SEL_W         8
`define TDBG_DATA_W        32
`define TDBG_ACCESS_INSTR  10'h07C
`define TDBG_IR_CAPTURE    10'h001
`define TDBG_IR_RST        10'h3FF
`define TDBG_SEL_RST       8'h00
`define TDBG_DIR_BIT       0
`define TDBG_TC_IB         6'h04
`define TDBG_TC_IBS        6'h0C
`define TDBG_TC_CORR       6'h21
`define TDBG_TC_DW         6'h05
`define TDBG_TC_DR         6'h06
`define TDBG_TC_DWS        6'h0D
`define TDBG_TC_DRS        6'h0E
`define TDBG_CTRL_OFS      8'h00
`define TDBG_STAT_OFS      8'h04
`define TDBG_SRC_OFS       8'h08
`define TDBG_CTRL_RST      32'h0000_1003
`define TDBG_CTRL_PT_EN    0
`define TDBG_CTRL_DT_EN    1
`define TDBG_PER_LSB       8
`define TDBG_PER_MSB       15
`endif

//--- verilog/tdbg_pkg.sv
// Types for the trace debug access and message field block
package tdbg_pkg;
	typedef enum logic [3:0] {
		TDBG_TLR   = 4'h0, TDBG_RTI   = 4'h1, TDBG_SELDR = 4'h3,
		TDBG_CAPDR = 4'h2, TDBG_SHDR  = 4'h6, TDBG_EX1DR = 4'h7,
		TDBG_UPDDR = 4'h5, TDBG_PSDR  = 4'h4, TDBG_EX2DR = 4'hC,
		TDBG_SELIR = 4'hD, TDBG_CAPIR = 4'hF, TDBG_SHIR  = 4'hE,
		TDBG_EX1IR = 4'hA, TDBG_PSIR  = 4'hB, TDBG_EX2IR = 4'h9,
		TDBG_UPDIR = 4'h8
	} tdbg_tap_t;
	typedef enum logic [1:0] {
		TDBG_PT_BRANCH = 2'h0,
		TDBG_PT_EXC    = 2'h1,
		TDBG_PT_MTMSR  = 2'h3
	} tdbg_pt_cause_t;
endpackage

//--- verilog/tdbg_reladdr.sv
// Relative or full address field former for one trace type
`timescale 1ns/1ps
`default_nettype none
module tdbg_reladdr #(
	parameter int AW = 32,
	parameter int BW = 6
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// Event
	input  wire logic          fire_i,
	input  wire logic          full_i,
	input  wire logic [AW-1:0] addr_i,
	// Field
	output logic      [AW-1:0] addr_o,
	output logic      [BW-1:0] bits_o
);
	logic [AW-1:0] prev;

	// ****************************************
	// Field forming
	// ****************************************
	always_comb begin
		addr_o = full_i ? addr_i : (addr_i ^ prev); // R12 R15
		bits_o = '0;
		for (int i = 0; i < AW; i++) begin
			if (addr_o[i])
				bits_o = BW'(i + 1); // R12 R15
		end
	end

	// Reference follows this trace type only
	always_ff @(posedge clk_i) begin
		if (rst_i)
			prev <= '0;
		else if (fire_i)
			prev <= addr_i; // R11
	end
endmodule // tdbg_reladdr
`default_nettype wire

//--- verilog/tdbg_top.sv
// Trace debug register access over the test port and message fields
//
// Contract
// R1 - Access instruction code 0b0001111100 must be loaded before register access.
// R2 - Each register access takes two data-scan passes: select, then data.
// R3 - First pass carries index and direction; 0 reads, 1 writes.
// R4 - Selection value is 8 bits: 7-bit index, 1 direction; resets to zero.
// R5 - Second pass shifts register data least significant bit first.
// R6 - Read copies selected register into shift path at Capture-DR.
// R7 - Write loads shifted data into selected register at Update-DR.
// R8 - Packet holds fixed fields then at most one variable field, last.
// R9 - Every message has a 6-bit message type code.
// R10 - Every message has a 4-bit source id taken from the input.
// R11 - Non-sync program and data messages send relative addresses.
// R12 - Relative address is XOR with previous, trimmed above highest one.
// R13 - Program reference is the last program message only.
// R14 - Data reference is the last data message only.
// R15 - Program sync messages carry full address, leading zeros dropped.
// R16 - Sync messages on mode changes and periodically.
// R17 - Data message space field holds the data-space bit of the access.
// R18 - Indirect program message space field holds the new space value.
// R19 - Exception or return sends indirect branch with new space, count, history.
// R20 - Move to machine state sends correlation with new space, count, history.
// R21 - Direction bit is selection bit 0, shifted first; index above.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tdbg_defines.svh"
module tdbg_top import tdbg_pkg::*; #(
	parameter int NREG = 16,
	parameter int AW   = 32,
	parameter int CW   = 8
) (
	// Clock and reset
	input  wire logic          REF_CLK_I,
	input  wire logic          RST_I,
	// Test port pins
	input  wire logic          TCK_I,
	input  wire logic          TMS_I,
	input  wire logic          TDI_I,
	output logic               TDO_O,
	output logic               TDO_OE_N_O,
	// APB slave
	input  wire logic          PSEL_I,
	input  wire logic          PENABLE_I,
	input  wire logic          PWRITE_I,
	input  wire logic [7:0]    PADDR_I,
	input  wire logic [31:0]   PWDATA_I,
	output logic      [31:0]   PRDATA_O,
	output logic               PREADY_O,
	output logic               PSLVERR_O,
	// Trace events
	input  wire logic          PT_VALID_I,
	input  wire logic [1:0]    PT_CAUSE_I,
	input  wire logic [AW-1:0] PT_ADDR_I,
	input  wire logic          PT_NEW_IS_I,
	input  wire logic [CW-1:0] PT_INSTRUCTION_COUNT_I,
	input  wire logic [31:0]   PT_BRANCH_HISTORY_I,
	input  wire logic          DT_VALID_I,
	input  wire logic          DT_WRITE_I,
	input  wire logic [AW-1:0] DT_ADDR_I,
	input  wire logic          DT_DS_I,
	input  wire logic          MODE_CHG_I,
	input  wire logic [3:0]    EXT_SOURCE_ID_IN_I,
	// Message fields
	output logic               MSG_VALID_O,
	output logic      [5:0]    MESSAGE_TYPE_CODE_O,
	output logic      [3:0]    MSG_SRC_O,
	output logic               MSG_MAP_O,
	output logic      [CW-1:0] INSTRUCTION_COUNT_O,
	output logic      [31:0]   BRANCH_HISTORY_O,
	output logic      [AW-1:0] MSG_ADDR_O,
	output logic      [5:0]    MSG_ADDR_BITS_O
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic       tck_d;
	logic       tck_rise;
	logic       tck_fall;
	logic       tms;
	logic       tdi;

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
			tck_d  <= 1'b0;
		end else begin
			pin_s1 <= {TCK_I, TMS_I, TDI_I};
			pin_s2 <= pin_s1;
			tck_d  <= pin_s2[2];
		end
	end

	// TCK at 200 ns gives eight samples per period; edges are clean
	assign tck_rise = pin_s2[2] & ~tck_d;
	assign tck_fall = ~pin_s2[2] & tck_d;
	assign tms      = pin_s2[1];
	assign tdi      = pin_s2[0];

	// ****************************************
	// Test state machine
	// ****************************************
	tdbg_tap_t                  state;
	logic [`TDBG_IR_W-1:0]      ir;
	logic [`TDBG_IR_W-1:0]      ir_sh;
	logic [`TDBG_DATA_W-1:0]    dr;
	logic [`TDBG_SEL_W-1:0]     sel;
	logic                       data_pass;
	logic [`TDBG_DATA_W-1:0]    trace_reg [NREG];
	logic                       access;
	logic [6:0]                 idx;
	logic                       idx_ok;
	logic [`TDBG_DATA_W-1:0]    rd_val;

	function automatic tdbg_tap_t tap_next(tdbg_tap_t s, logic m);
		case (s)
			TDBG_TLR:   tap_next = m ? TDBG_TLR   : TDBG_RTI;
			TDBG_RTI:   tap_next = m ? TDBG_SELDR : TDBG_RTI;
			TDBG_SELDR: tap_next = m ? TDBG_SELIR : TDBG_CAPDR;
			TDBG_CAPDR: tap_next = m ? TDBG_EX1DR : TDBG_SHDR;
			TDBG_SHDR:  tap_next = m ? TDBG_EX1DR : TDBG_SHDR;
			TDBG_EX1DR: tap_next = m ? TDBG_UPDDR : TDBG_PSDR;
			TDBG_PSDR:  tap_next = m ? TDBG_EX2DR : TDBG_PSDR;
			TDBG_EX2DR: tap_next = m ? TDBG_UPDDR : TDBG_SHDR;
			TDBG_UPDDR: tap_next = m ? TDBG_SELDR : TDBG_RTI;
			TDBG_SELIR: tap_next = m ? TDBG_TLR   : TDBG_CAPIR;
			TDBG_CAPIR: tap_next = m ? TDBG_EX1IR : TDBG_SHIR;
			TDBG_SHIR:  tap_next = m ? TDBG_EX1IR : TDBG_SHIR;
			TDBG_EX1IR: tap_next = m ? TDBG_UPDIR : TDBG_PSIR;
			TDBG_PSIR:  tap_next = m ? TDBG_EX2IR : TDBG_PSIR;
			TDBG_EX2IR: tap_next = m ? TDBG_UPDIR : TDBG_SHIR;
			TDBG_UPDIR: tap_next = m ? TDBG_SELDR : TDBG_RTI;
			default:    tap_next = TDBG_TLR;
		endcase
	endfunction

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I)
			state <= TDBG_TLR;
		else if (tck_rise)
			state <= tap_next(state, tms);
	end

	// Instruction register
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			ir    <= `TDBG_IR_RST;
			ir_sh <= `TDBG_IR_RST;
		end else if (tck_rise) begin
			case (state)
				TDBG_TLR:   ir    <= `TDBG_IR_RST;
				TDBG_CAPIR: ir_sh <= `TDBG_IR_CAPTURE;
				TDBG_SHIR:  ir_sh <= {tdi, ir_sh[`TDBG_IR_W-1:1]};
				TDBG_UPDIR: ir    <= ir_sh;
				default: ;
			endcase
		end
	end

	assign access = (ir == `TDBG_ACCESS_INSTR); // R1
	assign idx    = sel[`TDBG_SEL_W-1:1]; // R21
	assign idx_ok = (32'(idx) < NREG);
	assign rd_val = idx_ok ? trace_reg[idx[$clog2(NREG)-1:0]] : '0;

	// Data shift path
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I)
			dr <= '0;
		else if (tck_rise) begin
			case (state)
				TDBG_CAPDR: begin
					if (access && data_pass && !sel[`TDBG_DIR_BIT])
						dr <= rd_val; // R6
					else if (access && !data_pass)
						dr <= {24'h0, sel};
					else
						dr[0] <= 1'b0;
				end
				TDBG_SHDR: begin
					if (access && data_pass)
						dr <= {tdi, dr[`TDBG_DATA_W-1:1]}; // R5
					else if (access)
						dr[7:0] <= {tdi, dr[7:1]}; // R4 R21
					else
						dr[0] <= tdi;
				end
				default: ;
			endcase
		end
	end

	// Selection value and pass tracking
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			sel       <= `TDBG_SEL_RST; // R4
			data_pass <= 1'b0;
		end else if (tck_rise) begin
			if (state == TDBG_TLR || state == TDBG_UPDIR) begin
				sel       <= `TDBG_SEL_RST;
				data_pass <= 1'b0;
			end else if (state == TDBG_UPDDR && access) begin
				if (!data_pass)
					sel <= dr[`TDBG_SEL_W-1:0]; // R3
				data_pass <= ~data_pass; // R2
			end
		end
	end

	// Debug register array; out-of-range writes are dropped
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			for (int i = 0; i < NREG; i++)
				trace_reg[i] <= '0;
		end else if (tck_rise && state == TDBG_UPDDR && access &&
			data_pass && sel[`TDBG_DIR_BIT] && idx_ok) begin
			trace_reg[idx[$clog2(NREG)-1:0]] <= dr; // R7
		end
	end

	// Output changes on the falling edge so the tool samples it stable
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			TDO_O      <= 1'b0;
			TDO_OE_N_O <= 1'b1;
		end else if (tck_fall) begin
			TDO_O      <= (state == TDBG_SHIR) ? ir_sh[0] : dr[0];
			TDO_OE_N_O <= !(state == TDBG_SHIR || state == TDBG_SHDR);
		end
	end

	// ****************************************
	// APB registers
	// ****************************************
	logic [31:0] ctrl;
	logic [15:0] msg_cnt;
	logic [5:0]  last_tc;
	logic        apb_acc;
	logic        mapped;
	logic [31:0] apb_rd;

	assign apb_acc = PSEL_I & PENABLE_I;
	assign mapped  = PADDR_I == `TDBG_CTRL_OFS ||
		PADDR_I == `TDBG_STAT_OFS || PADDR_I == `TDBG_SRC_OFS;

	always_comb begin
		case (PADDR_I)
			`TDBG_CTRL_OFS: apb_rd = ctrl;
			`TDBG_STAT_OFS: apb_rd = {10'h0, last_tc, msg_cnt};
			`TDBG_SRC_OFS:  apb_rd = {28'h0, EXT_SOURCE_ID_IN_I};
			default:        apb_rd = 32'h0;
		endcase
	end

	// One wait state: ready rises on the second access-phase cycle
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h0;
		end else begin
			PREADY_O  <= apb_acc & ~PREADY_O;
			PSLVERR_O <= apb_acc & ~PREADY_O & ~mapped;
			if (apb_acc && !PREADY_O)
				PRDATA_O <= PWRITE_I ? 32'h0 : apb_rd;
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I)
			ctrl <= `TDBG_CTRL_RST;
		else if (apb_acc && PREADY_O && PWRITE_I &&
			PADDR_I == `TDBG_CTRL_OFS)
			ctrl <= PWDATA_I;
	end

	// ****************************************
	// Message forming
	// ****************************************
	logic          pt_go;
	logic          pt_addr;
	logic          dt_want;
	logic          dt_go;
	logic          pt_sync;
	logic          dt_sync;
	logic [7:0]    per_cnt;
	logic          per_hit;
	logic [AW-1:0] pt_field;
	logic [5:0]    pt_bits;
	logic [AW-1:0] dt_field;
	logic [5:0]    dt_bits;
	logic [5:0]    next_tc;

	assign pt_go   = PT_VALID_I & ctrl[`TDBG_CTRL_PT_EN];
	assign pt_addr = pt_go & (PT_CAUSE_I != TDBG_PT_MTMSR);
	assign dt_want = DT_VALID_I & ctrl[`TDBG_CTRL_DT_EN];
	// Single output lane: program trace wins, a lost data event forces sync
	assign dt_go   = dt_want & ~pt_go;
	assign per_hit = (ctrl[`TDBG_PER_MSB:`TDBG_PER_LSB] != 8'h00) &&
		(per_cnt >= ctrl[`TDBG_PER_MSB:`TDBG_PER_LSB]);

	// Separate references keep the two trace types apart
	tdbg_reladdr #(.AW(AW), .BW(6)) u_pt_ref ( // R13
		.clk_i  (REF_CLK_I),
		.rst_i  (RST_I),
		.fire_i (pt_addr),
		.full_i (pt_sync),
		.addr_i (PT_ADDR_I),
		.addr_o (pt_field),
		.bits_o (pt_bits)
	);

	tdbg_reladdr #(.AW(AW), .BW(6)) u_dt_ref ( // R14
		.clk_i  (REF_CLK_I),
		.rst_i  (RST_I),
		.fire_i (dt_go),
		.full_i (dt_sync),
		.addr_i (DT_ADDR_I),
		.addr_o (dt_field),
		.bits_o (dt_bits)
	);

	// Sync requests: a new cause wins over the clear by a sent message
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			pt_sync <= 1'b1;
			dt_sync <= 1'b1;
		end else begin
			pt_sync <= (pt_sync & ~pt_addr) | MODE_CHG_I | per_hit; // R16
			dt_sync <= (dt_sync & ~dt_go) | MODE_CHG_I | per_hit |
				(dt_want & pt_go); // R16
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I)
			per_cnt <= 8'h00;
		else if (per_hit)
			per_cnt <= 8'h00;
		else if (pt_go || dt_go)
			per_cnt <= per_cnt + 8'h01; // R16
	end

	always_comb begin
		if (pt_go && PT_CAUSE_I == TDBG_PT_MTMSR)
			next_tc = `TDBG_TC_CORR; // R20
		else if (pt_go)
			next_tc = pt_sync ? `TDBG_TC_IBS : `TDBG_TC_IB; // R19
		else if (DT_WRITE_I)
			next_tc = dt_sync ? `TDBG_TC_DWS : `TDBG_TC_DW;
		else
			next_tc = dt_sync ? `TDBG_TC_DRS : `TDBG_TC_DR;
	end

	// Fixed fields first, address is the only variable field, last
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			MSG_VALID_O         <= 1'b0;
			MESSAGE_TYPE_CODE_O <= 6'h00;
			MSG_SRC_O           <= 4'h0;
			MSG_MAP_O           <= 1'b0;
			INSTRUCTION_COUNT_O <= '0;
			BRANCH_HISTORY_O    <= 32'h0;
			MSG_ADDR_O          <= '0;
			MSG_ADDR_BITS_O     <= 6'h00;
		end else begin
			MSG_VALID_O <= pt_go | dt_go;
			if (pt_go || dt_go) begin
				MESSAGE_TYPE_CODE_O <= next_tc; // R9
				MSG_SRC_O           <= EXT_SOURCE_ID_IN_I; // R10
				MSG_MAP_O           <= pt_go ? PT_NEW_IS_I : DT_DS_I; // R17 R18
				INSTRUCTION_COUNT_O <= pt_go ? PT_INSTRUCTION_COUNT_I : '0; // R19 R20
				BRANCH_HISTORY_O    <= pt_go ? PT_BRANCH_HISTORY_I : 32'h0;
				MSG_ADDR_O          <= !pt_go ? dt_field :
					pt_addr ? pt_field : '0; // R8 R11 R15
				MSG_ADDR_BITS_O     <= !pt_go ? dt_bits :
					pt_addr ? pt_bits : 6'h00; // R8
			end
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			msg_cnt <= 16'h0000;
			last_tc <= 6'h00;
		end else if (pt_go || dt_go) begin
			msg_cnt <= msg_cnt + 16'h0001;
			last_tc <= next_tc;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);

	chk_access_load: assert property (tck_rise && state == TDBG_UPDIR // R1
		&& ir_sh == `TDBG_ACCESS_INSTR |=> access)
		else $error("access instruction not taken");
	chk_two_pass: assert property (tck_rise && state == TDBG_UPDDR // R2
		&& access && !data_pass |=> data_pass ##0 $stable(ir))
		else $error("second pass not armed");
	chk_sel_take: assert property (tck_rise && state == TDBG_UPDDR // R3
		&& access && !data_pass |=> sel == $past(dr[7:0]))
		else $error("selection not loaded");
	chk_sel_reset: assert property (disable iff (1'b0) // R4
		RST_I |=> sel == `TDBG_SEL_RST)
		else $error("selection not cleared");
	chk_lsb_first: assert property (tck_rise && state == TDBG_SHDR // R5
		&& access && data_pass |=> dr[31] == $past(tdi)
		&& dr[30:0] == $past(dr[31:1]))
		else $error("data not shifted lsb first");
	chk_read_cap: assert property (tck_rise && state == TDBG_CAPDR // R6
		&& access && data_pass && !sel[0] |=> dr == $past(rd_val))
		else $error("read data not captured");
	chk_write_upd: assert property (tck_rise && state == TDBG_UPDDR // R7
		&& access && data_pass && sel[0] && idx_ok |=> rd_val == $past(dr))
		else $error("write data not stored");
	chk_src_field: assert property (pt_go || dt_go // R10
		|=> MSG_VALID_O && MSG_SRC_O == $past(EXT_SOURCE_ID_IN_I))
		else $error("source id wrong");
	chk_data_map: assert property (dt_go // R17
		|=> MSG_MAP_O == $past(DT_DS_I) && MESSAGE_TYPE_CODE_O[5:4] == 2'h0)
		else $error("data space bit wrong");
	chk_exc_msg: assert property (pt_go && PT_CAUSE_I == TDBG_PT_EXC // R19
		|=> MSG_MAP_O == $past(PT_NEW_IS_I) && (MESSAGE_TYPE_CODE_O ==
		`TDBG_TC_IB || MESSAGE_TYPE_CODE_O == `TDBG_TC_IBS))
		else $error("exception message wrong");
	chk_mtmsr_corr: assert property (pt_go && PT_CAUSE_I == TDBG_PT_MTMSR // R20
		|=> MESSAGE_TYPE_CODE_O == `TDBG_TC_CORR
		&& INSTRUCTION_COUNT_O == $past(PT_INSTRUCTION_COUNT_I))
		else $error("correlation message wrong");
	chk_mode_sync: assert property (MODE_CHG_I ##1 pt_addr // R15 R16
		|=> MESSAGE_TYPE_CODE_O == `TDBG_TC_IBS)
		else $error("sync not sent after mode change");

	cov_reg_write: cover property (tck_rise && state == TDBG_UPDDR
		&& access && data_pass && sel[0]);
	cov_reg_read: cover property (tck_rise && state == TDBG_CAPDR
		&& access && data_pass && !sel[0]);
	cov_dt_lost: cover property (dt_want && pt_go);
	cov_rel_addr: cover property (pt_addr && !pt_sync);
endmodule // tdbg_top
`default_nettype wire

//--- verification/tdbg_tool_model.sv
// Debug tool model driving the test port of the trace block
`timescale 1ns/1ps
`default_nettype none
module tdbg_tool_model (
	// Test port
	output var logic tck_o,
	output var logic tms_o,
	output var logic tdi_o,
	input  wire logic tdo_i
);
	// ****
	// Clocking
	// ****
	// TCK stands low between frames, so the block sees no stray edges
	initial begin
		tck_o = 1'h0;
		tms_o = 1'h0;
		tdi_o = 1'h0;
	end
	// One TCK period of 200 ns; TDO taken just before the rising edge
	task automatic tbit(input logic ms, input logic di, output logic dout);
		tms_o = ms;
		tdi_o = di;
		#100;
		dout = tdo_i;
		tck_o = 1'h1;
		#100;
		tck_o = 1'h0;
	endtask
	// ****
	// Scans
	// ****
	// One IR or DR pass from Run-Test/Idle back to Run-Test/Idle
	task automatic scan(input logic ir, input int n,
		input logic [31:0] din, output logic [31:0] dout);
		logic x;
		dout = '0;
		#7;
		tbit(1'h0, ~tdi_o, x);
		tbit(1'h1, ~tdi_o, x);
		if (ir)
			tbit(1'h1, ~tdi_o, x);
		tbit(1'h0, ~tdi_o, x);
		tbit(1'h0, ~tdi_o, x);
		for (int i = 0; i < n; i++)
			tbit(i == n - 1, din[i], dout[i]);
		tbit(1'h1, ~tdi_o, x);
		tbit(1'h0, ~tdi_o, x);
		// Released data line shows the inverse of its last value
		tdi_o = ~tdi_o;
	endtask
endmodule // tdbg_tool_model
`default_nettype wire

//--- verification/trace_debug_access_fields_test.sv
// Self-checking bench for the trace debug access and message fields
`timescale 1ns/1ps
`default_nettype none
`include "tdbg_defines.svh"
module trace_debug_access_fields_test;
	// ****
	// Signals
	// ****
	localparam logic [31:0] A1 = 32'h0003_FC01;
	localparam logic [31:0] A2 = 32'h0003_F365;
	logic        clk, rst, psel, pen, pwr, err, tck, tms, tdi;
	logic        pt_v, pt_is, dt_v, dt_w, dt_ds, mchg;
	logic        tdo, tdo_oe_n, pready, pslverr, mv, map;
	logic [1:0]  pt_c;
	logic [3:0]  sid, src;
	logic [5:0]  code, mbits;
	logic [7:0]  paddr, pt_n, instruction_count;
	logic [31:0] pwdata, pt_a, pt_h, dt_a, rd, d, prdata, branch_history, maddr;
	wire logic   tdo_w;
	int          fail_count, checks;
	// Pull-up holds the line while the block is not driving it
	assign tdo_w = tdo_oe_n ? 1'h1 : tdo;
	tdbg_top tdbg_top_inst (
		.REF_CLK_I(clk), .RST_I(rst), .TCK_I(tck), .TMS_I(tms),
		.TDI_I(tdi), .TDO_O(tdo), .TDO_OE_N_O(tdo_oe_n),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .PT_VALID_I(pt_v), .PT_CAUSE_I(pt_c),
		.PT_ADDR_I(pt_a), .PT_NEW_IS_I(pt_is), .PT_INSTRUCTION_COUNT_I(pt_n),
		.PT_BRANCH_HISTORY_I(pt_h), .DT_VALID_I(dt_v), .DT_WRITE_I(dt_w),
		.DT_ADDR_I(dt_a), .DT_DS_I(dt_ds), .MODE_CHG_I(mchg),
		.EXT_SOURCE_ID_IN_I(sid), .MSG_VALID_O(mv),
		.MESSAGE_TYPE_CODE_O(code), .MSG_SRC_O(src), .MSG_MAP_O(map),
		.INSTRUCTION_COUNT_O(instruction_count), .BRANCH_HISTORY_O(branch_history),
		.MSG_ADDR_O(maddr), .MSG_ADDR_BITS_O(mbits)
	);
	tdbg_tool_model tdbg_tool_model_inst (
		.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_w)
	);
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	// ****
	// Shared tasks
	// ****
	task automatic print_verdict();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	function automatic logic [5:0] nb(input logic [31:0] x);
		nb = 6'h00;
		for (int i = 0; i < 32; i++)
			if (x[i])
				nb = 6'(i + 1);
	endfunction
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1) begin
			fail_count++;
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	task automatic pt(input logic [1:0] c, input logic [31:0] a, input logic s);
		@(posedge clk);
		pt_v <= 1'h1;
		pt_c <= c;
		pt_a <= a;
		pt_is <= s;
		pt_n <= a[7:0] ^ 8'h5A;
		pt_h <= ~a;
		@(posedge clk);
		pt_v <= 1'h0;
		mchg <= 1'h0;
		#1;
	endtask
	task automatic dt(input logic w, input logic [31:0] a, input logic s);
		@(posedge clk);
		dt_v <= 1'h1;
		dt_w <= w;
		dt_a <= a;
		dt_ds <= s;
		@(posedge clk);
		dt_v <= 1'h0;
		#1;
	endtask
	task automatic chk_msg(input logic [5:0] c, input logic m,
		input logic [31:0] a, input logic [5:0] b);
		chk({mv, code, src, map, mbits}, {1'h1, c, sid, m, b});
		if (b != 6'h00)
			chk(maddr, a);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		chk({tdo_oe_n, tdo, mv, pready, pslverr}, 5'h10);
		apb(1'h0, `TDBG_CTRL_OFS, 32'h0);
		chk(rd, `TDBG_CTRL_RST);
		apb(1'h0, `TDBG_SRC_OFS, 32'h0);
		chk(rd[3:0], sid);
		apb(1'h1, 8'h0C, 32'hFFFF_FFFF);
		chk({err, rd}, {1'h1, 32'h0});
		apb(1'h0, 8'h0C, 32'h0);
		chk({err, rd}, {1'h1, 32'h0});
	endtask
	task automatic t_jtag();
		tdbg_tool_model_inst.scan(1'h1, 10, 32'(`TDBG_ACCESS_INSTR), d);
		tdbg_tool_model_inst.scan(1'h0, 8, 32'h07, d);
		tdbg_tool_model_inst.scan(1'h0, 32, 32'hC3A5_0F1E, d);
		tdbg_tool_model_inst.scan(1'h0, 8, 32'h1F, d);
		tdbg_tool_model_inst.scan(1'h0, 32, 32'h1234_5678, d);
		for (int i = 0; i < 2; i++) begin
			tdbg_tool_model_inst.scan(1'h0, 8, 32'h06, d);
			tdbg_tool_model_inst.scan(1'h0, 32, 32'hFFFF_FFFF, d);
			chk(d, 32'hC3A5_0F1E);
		end
		tdbg_tool_model_inst.scan(1'h0, 8, 32'h1E, d);
		tdbg_tool_model_inst.scan(1'h0, 32, 32'h0, d);
		chk(d, 32'h1234_5678);
		tdbg_tool_model_inst.scan(1'h0, 8, 32'h20, d);
		tdbg_tool_model_inst.scan(1'h0, 32, 32'h0, d);
		chk(d, 32'h0);
	endtask
	task automatic t_trace();
		int n;
		apb(1'h1, `TDBG_CTRL_OFS, 32'h0000_0003);
		pt(2'h0, A1, 1'h1);
		chk_msg(`TDBG_TC_IBS, 1'h1, A1, nb(A1));
		dt(1'h0, 32'h0000_0100, 1'h1);
		chk_msg(`TDBG_TC_DRS, 1'h1, 32'h0000_0100, 6'h09);
		pt(2'h0, A2, 1'h0);
		chk_msg(`TDBG_TC_IB, 1'h0, A1 ^ A2, nb(A1 ^ A2));
		chk(nb(A1 ^ A2), 6'h0C);
		dt(1'h1, 32'h0000_0104, 1'h0);
		chk_msg(`TDBG_TC_DW, 1'h0, 32'h0000_0004, 6'h03);
		pt(2'h1, A1, 1'h1);
		chk_msg(`TDBG_TC_IB, 1'h1, A1 ^ A2, nb(A1 ^ A2));
		chk({instruction_count, branch_history}, {8'h5B, ~A1});
		pt(2'h3, A2, 1'h0);
		chk_msg(`TDBG_TC_CORR, 1'h0, 32'h0, 6'h00);
		chk({instruction_count, branch_history}, {8'h3F, ~A2});
		pt(2'h0, A2, 1'h0);
		chk_msg(`TDBG_TC_IB, 1'h0, A1 ^ A2, nb(A1 ^ A2));
		@(posedge clk);
		mchg <= 1'h1;
		pt(2'h0, A1, 1'h1);
		chk_msg(`TDBG_TC_IBS, 1'h1, A1, nb(A1));
		sid <= 4'h5;
		dt(1'h1, 32'h0000_0104, 1'h1);
		chk_msg(`TDBG_TC_DWS, 1'h1, 32'h0000_0104, 6'h09);
		apb(1'h0, `TDBG_STAT_OFS, 32'h0);
		chk(rd[21:16], `TDBG_TC_DWS);
		apb(1'h1, `TDBG_CTRL_OFS, 32'h0000_0203);
		n = 0;
		for (int i = 0; i < 4; i++) begin
			pt(2'h0, i[0] ? A1 : A2, 1'h0);
			chk(code, i[0] ? `TDBG_TC_IB : `TDBG_TC_IBS);
			if (code === `TDBG_TC_IBS)
				n++;
		end
		chk(n, 32'h2);
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		fail_count = 0;
		checks = 0;
		rst = 1'h1;
		{psel, pen, pwr, pt_v, pt_is, dt_v, dt_w, dt_ds, mchg} = '0;
		{paddr, pwdata, pt_c, pt_a, pt_n, pt_h, dt_a} = '0;
		sid = 4'hA;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		repeat (4) @(posedge clk);
		t_reset();
		t_jtag();
		t_trace();
		print_verdict();
	end
endmodule // trace_debug_access_fields_test
`default_nettype wire
